// [rtl/pic_ctrl.sv]
// pic_ctrl.sv: priority interrupt controller with ahb-lite register slave
// assumes: one clock CLK, sync reset, pins asynchronous, peripherals and
// break unit and cpu on CLK
//
// Overview of operation
// - sources carry levels 0..16; programmable sources use 4-bit levels 0..15.
// - a source at level 0 is masked and never forwarded.
// - non-maskable request has level 16 and is accepted at any mask.
// - non-maskable input is edge detected; a control bit picks rising or falling.
// - accepting the non-maskable request loads cpu mask level 15.
// - break request has level 15, is edge detected and latched until accepted.
// - accepting the break request loads cpu mask level 15.
// - each of eight pins selects low-level or falling-edge sensing.
// - each pin has its own 4-bit level in the two pin priority registers.
// - level mode requests while pin is low; the flag follows the pin.
// - edge mode latches a high-to-low transition until accepted.
// - software clears a latched flag by writing 0 after reading 1.
// - accepting a pin request loads cpu mask with its programmed level.
// - peripheral sources have own vectors; each pair shares one level field in six priority registers.
// - accepting a peripheral request loads cpu mask with its level.
// - an output pin tells outside logic that a request is pending.
// - control register reads 0x8000 after reset with pin high, else 0x0000.
// - a read-only bit shows the current non-maskable pin level.
// - register accesses take two cycles, longword accesses four.
// - equal levels resolve by fixed order, also inside shared fields.
// - each source supplies its vector; pins use 64 to 71.
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_ctrl (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RESET,
  // ahb-lite slave
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  // device pins
  input  wire logic             NMI_PIN,
  input  wire logic [7:0]       EXT_REQUEST_PINS_N,
  output logic                  EVENT_NOTIFY_OUT_N,
  // on-chip sources
  input  wire logic             BREAK_UNIT_REQ,
  input  wire logic [47:0]      PERIPH_REQ,
  // cpu core
  input  wire logic [3:0]       CPU_MASK_LEVEL,
  input  wire logic             CPU_ACK,
  output pic_pkg::pic_req_s     CPU_REQ
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic idx_hit(input logic [29:0] word_addr,
                                   input logic [31:0] idx);
    idx_hit = (word_addr == idx[29:0]);
  endfunction : idx_hit

  // nibble n: register n/4, bits 15-12 first
  function automatic logic [3:0] nibble_of(
      input pic_pkg::pic_reg_t regs [0:7], input logic [4:0] n);
    nibble_of = regs[n[4:2]][(5'd3 - {3'd0, n[1:0]}) * 4 +: 4];
  endfunction : nibble_of

  // one compare of the presented source, shared by every clear path
  function automatic logic src_is(input pic_pkg::pic_src_t src,
                                  input pic_pkg::pic_src_t id);
    src_is = (src == id);
  endfunction : src_is

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic       nmi_s1_r;
  logic       nmi_s2_r;
  logic       nmi_d_r;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [7:0] pin_d_r;
  logic       brk_d_r;

  // idle levels at reset; control bit 15 trails the pin by two edges
  always_ff @(posedge CLK) begin
    if (RESET) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_d_r  <= 1'b0;
      pin_s1_r <= 8'hff;
      pin_s2_r <= 8'hff;
      pin_d_r  <= 8'hff;
      brk_d_r  <= 1'b0;
    end else begin
      nmi_s1_r <= NMI_PIN;
      nmi_s2_r <= nmi_s1_r;
      nmi_d_r  <= nmi_s2_r;
      pin_s1_r <= EXT_REQUEST_PINS_N;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
      brk_d_r  <= BREAK_UNIT_REQ;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  pic_pkg::pic_reg_t pri_r [0:7];
  logic        nmi_edge_r;
  logic [7:0]  sense_r;
  logic [7:0]  flag_r;
  logic [7:0]  seen_r;
  logic        busy_r;
  logic [1:0]  cnt_r;
  logic        wr_r;
  logic [29:0] waddr_r;
  logic        hready_r;
  logic [31:0] hrdata_r;

  wire logic addr_go = HSEL & HTRANS[1] & HREADY;
  wire logic last    = busy_r & (cnt_r == 2'h1);
  wire logic wr_go   = last & wr_r;
  wire logic rd_go   = last & ~wr_r;
  // slow accesses: longword four cycles, narrower two
  wire logic [1:0] wait_ld = (HSIZE == `PIC_HSIZE_WORD) ?
                             `PIC_WAIT_LONG : `PIC_WAIT_SHORT;

  wire logic hit_ctrl = idx_hit(waddr_r, `PIC_IDX_REQ_CTRL);
  wire logic hit_stat = idx_hit(waddr_r, `PIC_IDX_PIN_STATUS);
  logic [7:0] hit_pri;

  // priority word n answers at the first index plus two times n
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pri
      assign hit_pri[gi] = idx_hit(waddr_r,
                                   `PIC_IDX_PIN_PRI_A + 32'(2 * gi));
      always_ff @(posedge CLK) begin
        if (RESET) begin
          pri_r[gi] <= `PIC_PRI_RESET;
        end else if (wr_go && hit_pri[gi]) begin
          pri_r[gi] <= HWDATA[15:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------

  // input level bit shows the pin, so reset reads 0x8000 or 0x0000
  wire pic_pkg::pic_reg_t ctrl_rd = {nmi_s2_r, 6'h00, nmi_edge_r,
                                     sense_r};
  // status high byte unused, reads zero
  wire pic_pkg::pic_reg_t stat_rd = {8'h00, flag_r};

  // unmapped words read as zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      if (hit_pri[i]) begin
        rd_mux = pri_r[i];
      end
    end
    if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end
    if (hit_stat) begin
      rd_mux = stat_rd;
    end
  end

  // ---------------------------------------------------------------
  // bus timing
  // ---------------------------------------------------------------

  // writes land in the last data cycle; hwdata stands from the first
  always_ff @(posedge CLK) begin
    if (RESET) begin
      busy_r   <= 1'b0;
      cnt_r    <= 2'h0;
      wr_r     <= 1'b0;
      waddr_r  <= 30'h0;
      hready_r <= 1'b1;
      hrdata_r <= 32'h0;
    end else if (addr_go) begin
      busy_r   <= 1'b1;
      cnt_r    <= wait_ld;
      wr_r     <= HWRITE;
      waddr_r  <= HADDR[31:2];
      hready_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r    <= cnt_r - 2'h1;
      busy_r   <= ~last;
      hready_r <= last;
      if (rd_go) begin
        hrdata_r <= {16'h0000, rd_mux};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      nmi_edge_r <= 1'b0;
      sense_r    <= 8'h00;
    end else if (wr_go && hit_ctrl) begin
      nmi_edge_r <= HWDATA[`PIC_CTRL_NMI_EDGE];
      sense_r    <= HWDATA[`PIC_CTRL_SENSE_LSB +: 8];
    end
  end

  // ---------------------------------------------------------------
  // request sources
  // ---------------------------------------------------------------
  pic_pkg::pic_src_t src_r;
  logic      ack_go;
  logic      nmi_lat_r;
  logic      brk_lat_r;

  // an acknowledge counts only against a request actually shown
  assign ack_go = CPU_ACK & CPU_REQ.valid;

  wire logic nmi_rise = nmi_s2_r & ~nmi_d_r;
  wire logic nmi_fall = ~nmi_s2_r & nmi_d_r;
  wire logic nmi_set  = nmi_edge_r ? nmi_rise : nmi_fall;
  wire logic brk_set  = BREAK_UNIT_REQ & ~brk_d_r;
  wire logic nmi_clr  = ack_go & src_is(src_r, `PIC_SRC_NMI);
  wire logic brk_clr  = ack_go & src_is(src_r, `PIC_SRC_BRK);

  // a new edge in the acknowledge cycle survives
  always_ff @(posedge CLK) begin
    if (RESET) begin
      nmi_lat_r <= 1'b0;
      brk_lat_r <= 1'b0;
    end else begin
      nmi_lat_r <= nmi_set | (nmi_lat_r & ~nmi_clr);
      brk_lat_r <= brk_set | (brk_lat_r & ~brk_clr);
    end
  end

  // ---------------------------------------------------------------
  // pin flags
  // ---------------------------------------------------------------

  // status read with a 1 arms the clear by 0
  wire logic stat_rd_go = rd_go & hit_stat;
  wire logic stat_wr_go = wr_go & hit_stat;
  logic [7:0] pin_req;

  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      wire logic fall  = ~pin_s2_r[gi] & pin_d_r[gi];
      wire logic sw_cl = stat_wr_go & ~HWDATA[gi] & seen_r[gi];
      wire logic ack_c = ack_go &
                         src_is(src_r, `PIC_SRC_PIN0 + 6'(gi));
      always_ff @(posedge CLK) begin
        if (RESET) begin
          flag_r[gi] <= 1'b0;
          seen_r[gi] <= 1'b0;
        end else if (!sense_r[gi]) begin
          flag_r[gi] <= ~pin_s2_r[gi];
          seen_r[gi] <= 1'b0;
        end else begin
          flag_r[gi] <= fall | (flag_r[gi] & ~sw_cl & ~ack_c);
          seen_r[gi] <= (seen_r[gi] | (stat_rd_go & flag_r[gi]))
                        & ~sw_cl & ~ack_c;
        end
      end
      // level mode follows the pin directly, not the flag
      assign pin_req[gi] = sense_r[gi] ? flag_r[gi] : ~pin_s2_r[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  // level, vector and request of every source, in tie order
  logic [4:0] src_lvl [0:`PIC_NUM_SRC-1];
  logic [7:0] src_vec [0:`PIC_NUM_SRC-1];
  logic       src_on  [0:`PIC_NUM_SRC-1];

  assign src_lvl[0] = `PIC_LVL_NMI;
  assign src_vec[0] = `PIC_VEC_NMI;
  assign src_on[0]  = nmi_lat_r;
  assign src_lvl[1] = `PIC_LVL_BRK;
  assign src_vec[1] = `PIC_VEC_BRK;
  assign src_on[1]  = brk_lat_r;

  generate
    for (gi = 0; gi < `PIC_NUM_PINS; gi++) begin : g_pin_src
      assign src_lvl[2 + gi] = {1'b0, nibble_of(pri_r, 5'(gi))};
      assign src_vec[2 + gi] = `PIC_VEC_PIN0 + 8'(gi);
      assign src_on[2 + gi]  = pin_req[gi];
    end
    // two sources per peripheral field, lower one first
    for (gi = 0; gi < `PIC_NUM_PERI; gi++) begin : g_peri_src
      assign src_lvl[10 + gi] = {1'b0,
                                 nibble_of(pri_r, 5'(8 + gi / 2))};
      assign src_vec[10 + gi] = `PIC_VEC_PERI0 + 8'(gi);
      assign src_on[10 + gi]  = PERIPH_REQ[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // winner
  // ---------------------------------------------------------------

  // mask is one cycle old; a raised mask may see one stale request
  logic              best_on;
  logic [4:0]        best_lvl;
  pic_pkg::pic_src_t best_src;

  // scan in fixed order; strict compare keeps the earlier source on ties
  always_comb begin
    best_on  = 1'b0;
    best_lvl = 5'h00;
    best_src = 6'h00;
    for (int i = 0; i < `PIC_NUM_SRC; i++) begin
      if (src_on[i] && src_lvl[i] != 5'h00 &&
          src_lvl[i] > {1'b0, CPU_MASK_LEVEL} &&
          (!best_on || src_lvl[i] > best_lvl)) begin
        best_on  = 1'b1;
        best_lvl = src_lvl[i];
        best_src = 6'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // cpu request
  // ---------------------------------------------------------------

  // nmi and break load fixed mask 15; others their own level
  wire logic fixed_src = src_is(best_src, `PIC_SRC_NMI) ||
                         src_is(best_src, `PIC_SRC_BRK);
  wire logic [3:0] mask_nxt = fixed_src ? `PIC_MASK_FIXED
                                        : best_lvl[3:0];

  pic_pkg::pic_req_s req_r;
  logic              notify_n_r;

  // drop for one cycle after an acknowledge so a cleared latch is not re-sent
  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_r      <= '0;
      src_r      <= 6'h00;
      notify_n_r <= 1'b1;
    end else begin
      req_r.valid    <= best_on & ~ack_go;
      req_r.level    <= best_lvl;
      req_r.vector   <= src_vec[best_src];
      req_r.new_mask <= mask_nxt;
      src_r          <= best_src;
      notify_n_r     <= ~(best_on & ~ack_go);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign HRDATA             = hrdata_r;
  assign HREADYOUT          = hready_r;
  assign HRESP              = 1'b0;
  assign CPU_REQ            = req_r;
  assign EVENT_NOTIFY_OUT_N = notify_n_r;

endmodule : pic_ctrl

// [rtl/pic_regs.svh]
// pic_regs.svh: offsets, fields, reset values and counts of the controller
// assumes: included by bare name from the design file only
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define PIC_IDX_PIN_PRI_A    32'hffff8348
`define PIC_IDX_PIN_PRI_B    32'hffff834a
`define PIC_IDX_PERI_PRI_C   32'hffff834c
`define PIC_IDX_PERI_PRI_D   32'hffff834e
`define PIC_IDX_PERI_PRI_E   32'hffff8350
`define PIC_IDX_PERI_PRI_F   32'hffff8352
`define PIC_IDX_PERI_PRI_G   32'hffff8354
`define PIC_IDX_PERI_PRI_H   32'hffff8356
`define PIC_IDX_REQ_CTRL     32'hffff8358
`define PIC_IDX_PIN_STATUS   32'hffff835a

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define PIC_PRI_RESET        16'h0000
`define PIC_CTRL_RESET       16'h0000
`define PIC_STATUS_RESET     16'h0000
`define PIC_CTRL_NMI_LVL_BIT 15
`define PIC_CTRL_NMI_EDGE    8
`define PIC_CTRL_SENSE_LSB   0

// ---------------------------------------------------------------
// sources, levels and vectors
// ---------------------------------------------------------------
`define PIC_NUM_PINS         8
`define PIC_NUM_PERI         48
`define PIC_NUM_SRC          58
`define PIC_SRC_NMI          6'h00
`define PIC_SRC_BRK          6'h01
`define PIC_SRC_PIN0         6'h02
`define PIC_SRC_PERI0        6'h0a
`define PIC_LVL_NMI          5'h10
`define PIC_LVL_BRK          5'h0f
`define PIC_MASK_FIXED       4'hf
`define PIC_VEC_NMI          8'h0b
`define PIC_VEC_BRK          8'h0c
`define PIC_VEC_PIN0         8'h40
`define PIC_VEC_PERI0        8'h48

// ---------------------------------------------------------------
// bus timing: data phase cycles minus one
// ---------------------------------------------------------------
`define PIC_WAIT_SHORT       2'h1
`define PIC_WAIT_LONG        2'h3
`define PIC_HSIZE_WORD       3'h2

`endif

// [rtl/pic_pkg.sv]
// pic_pkg.sv: types shared by the priority controller
// assumes: constants come from pic_regs.svh
package pic_pkg;

  // one request as presented to the cpu core
  typedef struct packed {
    logic       valid;
    logic [4:0] level;
    logic [7:0] vector;
    logic [3:0] new_mask;
  } pic_req_s;

  typedef logic [5:0]  pic_src_t;
  typedef logic [15:0] pic_reg_t;

endpackage : pic_pkg

// [sim/pic_ctrl_assertions.sv]
// pic_ctrl_assertions.sv: port checks of the priority controller
// assumes: bound to pic_ctrl, one clock, HREADY tied to HREADYOUT
`timescale 1ns/1ps
module pic_ctrl_checker (
  // clock and reset
  input wire logic              CLK,
  input wire logic              RESET,
  // bus
  input wire logic              HSEL,
  input wire logic [1:0]        HTRANS,
  input wire logic [2:0]        HSIZE,
  input wire logic              HREADY,
  input wire logic              HREADYOUT,
  // cpu side
  input wire logic              EVENT_NOTIFY_OUT_N,
  input wire logic [3:0]        CPU_MASK_LEVEL,
  input wire logic              CPU_ACK,
  input wire pic_pkg::pic_req_s CPU_REQ
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  nmi_fixed_a: assert property (
    CPU_REQ.valid && CPU_REQ.vector == 8'h0b |->
    CPU_REQ.level == 5'h10 && CPU_REQ.new_mask == 4'hf)
    else $error("nmi level or mask wrong");
  brk_fixed_a: assert property (
    CPU_REQ.valid && CPU_REQ.vector == 8'h0c |->
    CPU_REQ.level == 5'h0f && CPU_REQ.new_mask == 4'hf)
    else $error("break level or mask wrong");
  no_zero_a: assert property (
    CPU_REQ.valid |-> CPU_REQ.level != 5'h00 && CPU_REQ.level <= 5'h10)
    else $error("level out of range forwarded");
  // one cycle lag: request was built from last cycle's mask
  above_mask_a: assert property (
    CPU_REQ.valid && CPU_REQ.level != 5'h10 |->
    !CPU_REQ.level[4] && CPU_REQ.level[3:0] > $past(CPU_MASK_LEVEL))
    else $error("request not above mask");
  mask_copy_a: assert property (
    CPU_REQ.valid && CPU_REQ.vector >= 8'h40 |->
    CPU_REQ.new_mask == CPU_REQ.level[3:0])
    else $error("new mask differs from level");
  vec_range_a: assert property (
    CPU_REQ.valid |-> CPU_REQ.vector inside {8'h0b, 8'h0c, [8'h40:8'h77]})
    else $error("vector out of range");
  notify_pin_a: assert property (
    EVENT_NOTIFY_OUT_N == !CPU_REQ.valid)
    else $error("notify pin disagrees with request");
  ack_clear_a: assert property (
    CPU_ACK && CPU_REQ.valid |=> !CPU_REQ.valid)
    else $error("request stays after ack");
  word_wait_a: assert property (
    HSEL && HTRANS[1] && HREADY && HSIZE == 3'h2 |=>
    !HREADYOUT [*3] ##1 HREADYOUT)
    else $error("word access length wrong");
endmodule : pic_ctrl_checker

bind pic_ctrl pic_ctrl_checker pic_ctrl_checker_inst (
  .CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS), .HSIZE(HSIZE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .EVENT_NOTIFY_OUT_N(EVENT_NOTIFY_OUT_N), .CPU_MASK_LEVEL(CPU_MASK_LEVEL),
  .CPU_ACK(CPU_ACK), .CPU_REQ(CPU_REQ));

// [sim/pic_cpu_model.sv]
// pic_cpu_model.sv: cpu core side, acks requests and keeps its mask
// assumes: same clock as the controller; lag sets answer speed
`timescale 1ns/1ps
module pic_cpu_model (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // controller side
  input wire pic_pkg::pic_req_s req,
  output logic                  ack,
  output logic [3:0]            mask,
  // bench side
  input wire logic [3:0]        lag,
  input wire logic              set_go,
  input wire logic [3:0]        set_val,
  output logic [7:0]            n_acks,
  output logic [7:0]            last_vec,
  output logic [3:0]            last_mask
);
  logic [3:0] cnt_r;
  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      {ack, mask, cnt_r, n_acks, last_vec, last_mask} <= '0;
    end else begin
      if (set_go) begin
        mask <= set_val;
      end
      if (ack) begin
        ack   <= 1'b0;
        cnt_r <= 4'h0;
        if (req.valid) begin
          // mask follows the accepted request
          mask      <= req.new_mask;
          n_acks    <= n_acks + 8'h01;
          last_vec  <= req.vector;
          last_mask <= req.new_mask;
        end
      end else if (req.valid) begin
        if (cnt_r >= lag) begin
          ack <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end else begin
        cnt_r <= 4'h0;
      end
    end
  end
endmodule : pic_cpu_model

// [sim/tb_priority_interrupt_controller.sv]
// tb_priority_interrupt_controller.sv: self-checking bench of pic_ctrl
// assumes: single ahb slave, cpu model on the far side
`timescale 1ns/1ps
module tb_priority_interrupt_controller;
  logic CLK = 0, RESET = 1, HSEL = 0, HWRITE = 0, NMI_PIN = 1, brk = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, seed = 32'h00016218, rd;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 0;
  logic [7:0] pins_n = 8'hff;
  logic [47:0] periph = 0;
  logic [3:0] lag = 0, set_val = 0;
  logic set_go = 0;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, notify_n, ack;
  wire [3:0] mask, last_mask;
  wire [7:0] n_acks, last_vec;
  pic_pkg::pic_req_s req;
  int fails = 0, total_checks = 0, cycles = 0;
  always #25 CLK = ~CLK;
  pic_ctrl pic_ctrl_inst (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .NMI_PIN(NMI_PIN),
    .EXT_REQUEST_PINS_N(pins_n), .EVENT_NOTIFY_OUT_N(notify_n),
    .BREAK_UNIT_REQ(brk), .PERIPH_REQ(periph), .CPU_MASK_LEVEL(mask),
    .CPU_ACK(ack), .CPU_REQ(req));
  pic_cpu_model pic_cpu_model_inst (.clk(CLK), .rst(RESET), .req(req),
    .ack(ack), .mask(mask), .lag(lag), .set_go(set_go), .set_val(set_val),
    .n_acks(n_acks), .last_vec(last_vec), .last_mask(last_mask));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] reg_addr(input int i);
    return 32'hfffe0d20 + 32'(i * 8);
  endfunction : reg_addr
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge CLK);
    {HSEL, HTRANS, HADDR, HWRITE, HSIZE} <= {1'b1, 2'h2, a, w, 3'h2};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, d};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    check("response", {31'h0, HRESP}, 32'h0);
  endtask : bus
  task automatic set_mask(input logic [3:0] v);
    @(posedge CLK);
    {set_go, set_val} <= {1'b1, v};
    @(posedge CLK);
    set_go <= 1'b0;
  endtask : set_mask
  task automatic take(input logic [7:0] n, vec, input logic [3:0] m);
    for (int k = 0; k < 80 && n_acks !== n; k++) @(posedge CLK);
    check("ack count", {24'h0, n_acks}, {24'h0, n});
    check("vector", {24'h0, last_vec}, {24'h0, vec});
    check("new mask", {28'h0, last_mask}, {28'h0, m});
  endtask : take
  task automatic print_verdict;
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // hang guard well above the few hundred cycles needed
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      bus(0, reg_addr(i), 0);
      check("reset value", rd, i == 8 ? 32'h8000 : 32'h0);
    end
    bus(0, 32'hfffe0d70, 0);
    check("unmapped", rd, 0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      bus(1, reg_addr(i), seed);
      bus(0, reg_addr(i), 0);
      check("priority", rd, {16'h0, seed[15:0]});
    end
    bus(1, reg_addr(9), 32'hffff);
    bus(0, reg_addr(9), 0);
    check("status ones", rd, 0);
    for (int i = 0; i < 8; i++)
      bus(1, reg_addr(i), i == 0 ? 32'h5300 : i == 2 ? 32'h7000 : 0);
    bus(1, reg_addr(8), 32'h0005);
    set_mask(4'hf);
    pins_n <= 8'hfa;
    repeat (3) @(posedge CLK);
    pins_n <= 8'hff;
    bus(0, reg_addr(9), 0);
    check("edge flags", rd, 32'h5);
    check("held by mask", {24'h0, n_acks}, 0);
    check("notify idle", {31'h0, notify_n}, 32'h1);
    lag <= seed[3:0];
    set_mask(4'h0);
    take(8'd1, 8'h40, 4'h5);
    bus(0, reg_addr(9), 0);
    check("after ack", rd, 32'h4);
    bus(1, reg_addr(9), 0);
    bus(0, reg_addr(9), 0);
    check("flag withdrawn", rd, 0);
    set_mask(4'h0);
    pins_n <= 8'hfd;
    take(8'd2, 8'h41, 4'h3);
    bus(0, reg_addr(9), 0);
    check("level flag", rd, 32'h2);
    pins_n <= 8'hff;
    bus(0, reg_addr(9), 0);
    check("level gone", rd, 0);
    set_mask(4'hf);
    NMI_PIN <= 1'b0;
    take(8'd3, 8'h0b, 4'hf);
    bus(0, reg_addr(8), 0);
    check("nmi low", rd, 32'h0005);
    bus(1, reg_addr(8), 32'h0105);
    NMI_PIN <= 1'b1;
    take(8'd4, 8'h0b, 4'hf);
    bus(0, reg_addr(8), 0);
    check("nmi high", rd, 32'h8105);
    set_mask(4'h0);
    lag <= 4'h7;
    brk <= 1'b1;
    @(posedge CLK);
    brk <= 1'b0;
    repeat (2) @(posedge CLK);
    check("notify low", {31'h0, notify_n}, 32'h0);
    take(8'd5, 8'h0c, 4'hf);
    set_mask(4'h0);
    periph <= 48'h3;
    take(8'd6, 8'h48, 4'h7);
    periph <= 48'h2;
    set_mask(4'h0);
    take(8'd7, 8'h49, 4'h7);
    periph <= 48'h0;
    print_verdict();
  end
endmodule : tb_priority_interrupt_controller
